// ==== pin_share_pkg.sv ====
// Functional notes
// - port B bit 0 is a software input or output pin whenever it is not the address line.
// - routed to the external bus, port B bit 0 carries address line 16 of memory accesses.
// - with bus_drive_keep clear, address line 16 and the bus control outputs float while the bus is idle.
// - after reset, port B bit 0 starts as I/O or address from the boot strap, width select and flash security.
// - a write to portb_periph_enable overrides the reset-time choice for port B bit 0, except one made before start-up completes, which that choice replaces.
// - bit 0 of portb_pullup_enable turns the port B bit 0 pull-up on when set and off when clear.
// - in external bus mode the seven shared pins carry data lines 0 to 6.
// - with bus_drive_keep clear, data lines 0 to 6 float while the bus is idle.
// - the seven data pins are port F bits 9 to 15, each its own input or output.
// - clearing a port F pull-up enable bit (bit 9 for data line 0) turns that pin's pull-up off.
package pin_share_pkg;
   // =========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_BUS_CTRL  = 8'h00;
   localparam logic [7:0] OFF_PB_PER    = 8'h04;
   localparam logic [7:0] OFF_PB_PUR    = 8'h08;
   localparam logic [7:0] OFF_PB_DIR    = 8'h0C;
   localparam logic [7:0] OFF_PB_DOUT   = 8'h10;
   localparam logic [7:0] OFF_PB_DIN    = 8'h14;
   localparam logic [7:0] OFF_PF_PER    = 8'h18;
   localparam logic [7:0] OFF_PF_PUR    = 8'h1C;
   localparam logic [7:0] OFF_PF_DIR    = 8'h20;
   localparam logic [7:0] OFF_PF_DOUT   = 8'h24;
   localparam logic [7:0] OFF_PF_DIN    = 8'h28;
   localparam logic [7:0] OFF_STATUS    = 8'h2C;
   // =========================================================
   // field layout
   localparam int PB_BIT       = 0;
   localparam int PF_LSB       = 9;
   localparam int PF_MSB       = 15;
   localparam int PF_WIDTH     = 7;
   localparam int DRV_BIT      = 0;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_BOOT_BIT  = 1;
   localparam int ST_INIT_BIT  = 2;
   localparam int CTRL_WIDTH   = 3;
   // =========================================================
   // reset values
   localparam logic       DRV_RST     = 1'b0;
   localparam logic       PB_PUR_RST  = 1'b1;
   localparam logic [6:0] PF_PER_RST  = 7'h7F;
   localparam logic [6:0] PF_PUR_RST  = 7'h7F;
   localparam logic [6:0] PF_ZERO     = 7'h00;
   localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
   // =========================================================
   // start-up timing: cycles to let the strap synchroniser settle
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;
   localparam logic [1:0] SETTLE_ZERO   = 2'h0;
   localparam logic [1:0] SETTLE_ONE    = 2'h1;
endpackage

// ==== ext_bus_gpio_pin_sharing.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module ext_bus_gpio_pin_sharing (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // reset-time straps (asynchronous pins)
   input  wire logic        external_boot_strap_in,
   input  wire logic        ext_iface_width_select_in,
   input  wire logic        flash_secure_in,
   // external memory interface core side
   input  wire logic        bus_active_in,
   input  wire logic        addr_line_16_in,
   input  wire logic [6:0]  data_line_wr_in,
   input  wire logic        data_drive_in,
   input  wire logic [2:0]  bus_ctrl_in,
   output logic      [6:0]  data_line_rd_out,
   // bus control pins
   output logic      [2:0]  bus_ctrl_pin_out,
   output logic             bus_ctrl_oe_out,
   // port b bit 0 / address line 16 pin
   input  wire logic        portb_bit0_pin_in,
   output logic             portb_bit0_pin_out,
   output logic             portb_bit0_oe_out,
   output logic             portb_bit0_pullup_out,
   // port f bits 9..15 / data lines 0..6 pins
   input  wire logic [6:0]  portf_bit9_pin_in,
   output logic      [6:0]  portf_bit9_pin_out,
   output logic      [6:0]  portf_bit9_oe_out,
   output logic      [6:0]  portf_bit9_pullup_out
);

   // =========================================================
   // declarations
   logic       bus_drive_keep_reg, bus_drive_keep_next;
   logic       portb_periph_enable_reg, portb_periph_enable_next;
   logic       portb_pullup_enable_reg, portb_pullup_enable_next;
   logic       pb_dir_reg, pb_dir_next;
   logic       pb_dout_reg, pb_dout_next;
   logic [6:0] pf_per_reg, pf_per_next;
   logic [6:0] portf_pullup_enable_reg, portf_pullup_enable_next;
   logic [6:0] pf_dir_reg, pf_dir_next;
   logic [6:0] pf_dout_reg, pf_dout_next;
   logic [1:0] settle_reg, settle_next;
   logic       init_done_reg, init_done_next;
   logic       boot_addr_reg, boot_addr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [10:0] sync1_reg, sync2_reg;
   logic [6:0] rd_data_reg, rd_data_next;
   logic       pb_in_s, strap_s, width_s, secure_s;
   logic [6:0] pf_in_s;
   logic       wr_en;
   logic       setup_en;
   logic       access_en;

   // =========================================================
   // helper functions
   // address decode: true for any mapped register
   function automatic logic mapped(input logic [7:0] a);
      unique case (a)
         pin_share_pkg::OFF_BUS_CTRL, pin_share_pkg::OFF_PB_PER, pin_share_pkg::OFF_PB_PUR,
         pin_share_pkg::OFF_PB_DIR, pin_share_pkg::OFF_PB_DOUT, pin_share_pkg::OFF_PB_DIN,
         pin_share_pkg::OFF_PF_PER, pin_share_pkg::OFF_PF_PUR, pin_share_pkg::OFF_PF_DIR,
         pin_share_pkg::OFF_PF_DOUT, pin_share_pkg::OFF_PF_DIN, pin_share_pkg::OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // place a port f field at bits 15..9 of a word
   function automatic logic [31:0] pf_word(input logic [6:0] f);
      pf_word = pin_share_pkg::WORD_ZERO;
      pf_word[pin_share_pkg::PF_MSB:pin_share_pkg::PF_LSB] = f;
   endfunction

   // place a single bit at a position of a word
   function automatic logic [31:0] bit_word(input logic b, input int pos);
      bit_word = pin_share_pkg::WORD_ZERO;
      bit_word[pos] = b;
   endfunction

   // reset-time start-up choice: address line when booting externally,
   // or when the wide external interface is selected and flash is open
   function automatic logic boot_as_addr(input logic strap, input logic width, input logic secure);
      boot_as_addr = strap | (width & ~secure);
   endfunction

   // =========================================================
   // two-stage synchronisers for every pin input and strap
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_reg <= 11'h000;
         sync2_reg <= 11'h000;
      end else begin
         sync1_reg <= {flash_secure_in, ext_iface_width_select_in, external_boot_strap_in,
                       portf_bit9_pin_in, portb_bit0_pin_in};
         sync2_reg <= sync1_reg;
      end
   end

   // split the synchronised word
   assign pb_in_s  = sync2_reg[0];
   assign pf_in_s  = sync2_reg[7:1];
   assign strap_s  = sync2_reg[8];
   assign width_s  = sync2_reg[9];
   assign secure_s = sync2_reg[10];

   // =========================================================
   // apb phase decode; the slave never waits
   assign setup_en    = psel_in & ~penable_in;
   assign access_en   = psel_in & penable_in;
   assign wr_en       = access_en & pwrite_in & mapped(paddr_in);
   assign pready_out  = 1'b1;
   assign pslverr_out = access_en & ~mapped(paddr_in);
   assign prdata_out  = prdata_reg;

   // =========================================================
   // start-up sequencer: waits for straps to settle, then picks mode
   always_comb begin
      settle_next    = settle_reg;
      init_done_next = init_done_reg;
      boot_addr_next = boot_addr_reg;
      if (!init_done_reg) begin
         if (settle_reg == pin_share_pkg::SETTLE_CYCLES) begin
            init_done_next = 1'b1;
            boot_addr_next = boot_as_addr(strap_s, width_s, secure_s);
         end else begin
            settle_next = 2'(settle_reg + pin_share_pkg::SETTLE_ONE);
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         settle_reg    <= pin_share_pkg::SETTLE_ZERO;
         init_done_reg <= 1'b0;
         boot_addr_reg <= 1'b0;
      end else begin
         settle_reg    <= settle_next;
         init_done_reg <= init_done_next;
         boot_addr_reg <= boot_addr_next;
      end
   end

   // =========================================================
   // register file next values
   always_comb begin
      bus_drive_keep_next      = bus_drive_keep_reg;
      portb_periph_enable_next = portb_periph_enable_reg;
      portb_pullup_enable_next = portb_pullup_enable_reg;
      pb_dir_next              = pb_dir_reg;
      pb_dout_next             = pb_dout_reg;
      pf_per_next              = pf_per_reg;
      portf_pullup_enable_next = portf_pullup_enable_reg;
      pf_dir_next              = pf_dir_reg;
      pf_dout_next             = pf_dout_reg;
      // start-up choice lands once, replacing any earlier software write; a write in the same cycle wins
      if (!init_done_reg && init_done_next) begin
         portb_periph_enable_next = boot_addr_next;
      end
      if (wr_en) begin
         unique case (paddr_in)
            pin_share_pkg::OFF_BUS_CTRL: bus_drive_keep_next = pwdata_in[pin_share_pkg::DRV_BIT];
            pin_share_pkg::OFF_PB_PER: portb_periph_enable_next = pwdata_in[pin_share_pkg::PB_BIT];
            pin_share_pkg::OFF_PB_PUR: portb_pullup_enable_next = pwdata_in[pin_share_pkg::PB_BIT];
            pin_share_pkg::OFF_PB_DIR: pb_dir_next = pwdata_in[pin_share_pkg::PB_BIT];
            pin_share_pkg::OFF_PB_DOUT: pb_dout_next = pwdata_in[pin_share_pkg::PB_BIT];
            pin_share_pkg::OFF_PF_PER: pf_per_next = pwdata_in[pin_share_pkg::PF_MSB:pin_share_pkg::PF_LSB];
            pin_share_pkg::OFF_PF_PUR: portf_pullup_enable_next = pwdata_in[pin_share_pkg::PF_MSB:pin_share_pkg::PF_LSB];
            pin_share_pkg::OFF_PF_DIR: pf_dir_next = pwdata_in[pin_share_pkg::PF_MSB:pin_share_pkg::PF_LSB];
            pin_share_pkg::OFF_PF_DOUT: pf_dout_next = pwdata_in[pin_share_pkg::PF_MSB:pin_share_pkg::PF_LSB];
            default: ; // read-only registers ignore writes
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_drive_keep_reg      <= pin_share_pkg::DRV_RST;
         portb_periph_enable_reg <= 1'b0;
         portb_pullup_enable_reg <= pin_share_pkg::PB_PUR_RST;
         pb_dir_reg              <= 1'b0;
         pb_dout_reg             <= 1'b0;
         pf_per_reg              <= pin_share_pkg::PF_PER_RST;
         portf_pullup_enable_reg <= pin_share_pkg::PF_PUR_RST;
         pf_dir_reg              <= pin_share_pkg::PF_ZERO;
         pf_dout_reg             <= pin_share_pkg::PF_ZERO;
      end else begin
         bus_drive_keep_reg      <= bus_drive_keep_next;
         portb_periph_enable_reg <= portb_periph_enable_next;
         portb_pullup_enable_reg <= portb_pullup_enable_next;
         pb_dir_reg              <= pb_dir_next;
         pb_dout_reg             <= pb_dout_next;
         pf_per_reg              <= pf_per_next;
         portf_pullup_enable_reg <= portf_pullup_enable_next;
         pf_dir_reg              <= pf_dir_next;
         pf_dout_reg             <= pf_dout_next;
      end
   end

   // =========================================================
   // read data, captured in the setup cycle
   always_comb begin
      prdata_next = prdata_reg;
      if (setup_en) begin
         unique case (paddr_in)
            pin_share_pkg::OFF_BUS_CTRL: prdata_next = bit_word(bus_drive_keep_reg, pin_share_pkg::DRV_BIT);
            pin_share_pkg::OFF_PB_PER: prdata_next = bit_word(portb_periph_enable_reg, pin_share_pkg::PB_BIT);
            pin_share_pkg::OFF_PB_PUR: prdata_next = bit_word(portb_pullup_enable_reg, pin_share_pkg::PB_BIT);
            pin_share_pkg::OFF_PB_DIR: prdata_next = bit_word(pb_dir_reg, pin_share_pkg::PB_BIT);
            pin_share_pkg::OFF_PB_DOUT: prdata_next = bit_word(pb_dout_reg, pin_share_pkg::PB_BIT);
            pin_share_pkg::OFF_PB_DIN: prdata_next = bit_word(pb_in_s, pin_share_pkg::PB_BIT);
            pin_share_pkg::OFF_PF_PER: prdata_next = pf_word(pf_per_reg);
            pin_share_pkg::OFF_PF_PUR: prdata_next = pf_word(portf_pullup_enable_reg);
            pin_share_pkg::OFF_PF_DIR: prdata_next = pf_word(pf_dir_reg);
            pin_share_pkg::OFF_PF_DOUT: prdata_next = pf_word(pf_dout_reg);
            pin_share_pkg::OFF_PF_DIN: prdata_next = pf_word(pf_in_s);
            pin_share_pkg::OFF_STATUS: prdata_next = bit_word(bus_active_in, pin_share_pkg::ST_BUSY_BIT)
                                                   | bit_word(boot_addr_reg, pin_share_pkg::ST_BOOT_BIT)
                                                   | bit_word(init_done_reg, pin_share_pkg::ST_INIT_BIT);
            default: prdata_next = pin_share_pkg::WORD_ZERO; // unmapped reads zero
         endcase
      end
   end

   // read data for the memory interface, taken from synchronised pins
   always_comb begin
      rd_data_next = pf_in_s;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_reg  <= pin_share_pkg::WORD_ZERO;
         rd_data_reg <= pin_share_pkg::PF_ZERO;
      end else begin
         prdata_reg  <= prdata_next;
         rd_data_reg <= rd_data_next;
      end
   end

   assign data_line_rd_out = rd_data_reg;

   // =========================================================
   // pin multiplexers; drivers held off until start-up completes
   assign bus_ctrl_pin_out = bus_ctrl_in;
   assign bus_ctrl_oe_out  = init_done_reg & (bus_active_in | bus_drive_keep_reg);

   // port b bit 0: address line 16 or general-purpose pin
   assign portb_bit0_pin_out = portb_periph_enable_reg ? addr_line_16_in : pb_dout_reg;
   assign portb_bit0_oe_out  = init_done_reg & (portb_periph_enable_reg ?
                                                (bus_active_in | bus_drive_keep_reg)
                                                : pb_dir_reg);
   assign portb_bit0_pullup_out = portb_pullup_enable_reg;

   // port f bits 9..15: data lines 0..6 or general-purpose pins, bit by bit
   always_comb begin
      for (int i = 0; i < pin_share_pkg::PF_WIDTH; i++) begin
         if (pf_per_reg[i]) begin
            portf_bit9_pin_out[i] = data_line_wr_in[i];
            portf_bit9_oe_out[i]  = init_done_reg & (bus_active_in ? data_drive_in
                                                                   : bus_drive_keep_reg);
         end else begin
            portf_bit9_pin_out[i] = pf_dout_reg[i];
            portf_bit9_oe_out[i]  = init_done_reg & pf_dir_reg[i];
         end
      end
   end
   assign portf_bit9_pullup_out = portf_pullup_enable_reg;

   // =========================================================
   // checks
   sequence s_pb_write(v);
      wr_en && paddr_in == pin_share_pkg::OFF_PB_PER && pwdata_in[pin_share_pkg::PB_BIT] == v;
   endsequence
   sequence s_startup_done;
      !init_done_reg ##1 init_done_reg;
   endsequence

   a_pb_gpio_out: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg && !portb_periph_enable_reg |-> portb_bit0_oe_out == pb_dir_reg
                                                    && portb_bit0_pin_out == pb_dout_reg)
      else $error("port b gpio drive wrong");
   a_addr16_route: assert property (@(posedge clk_in) disable iff (rst_in)
      portb_periph_enable_reg |-> portb_bit0_pin_out == addr_line_16_in)
      else $error("address line 16 not routed");
   a_idle_addr_float: assert property (@(posedge clk_in) disable iff (rst_in)
      !bus_drive_keep_reg && !bus_active_in && portb_periph_enable_reg
      |-> !portb_bit0_oe_out && !bus_ctrl_oe_out)
      else $error("address or control driven while idle");
   // the boot choice lands one edge after the synchronised straps are sampled
   a_boot_select: assert property (@(posedge clk_in) disable iff (rst_in)
      s_startup_done |-> portb_periph_enable_reg == boot_as_addr($past(strap_s, 1), $past(width_s, 1),
                                                                 $past(secure_s, 1)))
      else $error("start-up mode wrong");
   a_per_write: assert property (@(posedge clk_in) disable iff (rst_in)
      (init_done_reg and s_pb_write(1'b1)) |=> portb_periph_enable_reg ##1 portb_bit0_pin_out == addr_line_16_in)
      else $error("peripheral enable write lost");
   a_pb_pullup: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en && paddr_in == pin_share_pkg::OFF_PB_PUR
      |=> portb_bit0_pullup_out == $past(pwdata_in[pin_share_pkg::PB_BIT]))
      else $error("port b pull-up not following register");
   a_idle_data_float: assert property (@(posedge clk_in) disable iff (rst_in)
      !bus_drive_keep_reg && !bus_active_in |-> (portf_bit9_oe_out & pf_per_reg) == pin_share_pkg::PF_ZERO)
      else $error("data lines driven while idle");
   a_pf_gpio: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg |-> ((portf_bit9_oe_out ^ pf_dir_reg) & ~pf_per_reg) == pin_share_pkg::PF_ZERO)
      else $error("port f gpio direction wrong");
   a_pf_pullup: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en && paddr_in == pin_share_pkg::OFF_PF_PUR
      |=> portf_bit9_pullup_out == $past(pwdata_in[pin_share_pkg::PF_MSB:pin_share_pkg::PF_LSB]))
      else $error("port f pull-up not following register");
   a_startup_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
      !init_done_reg |-> !portb_bit0_oe_out && portf_bit9_oe_out == pin_share_pkg::PF_ZERO && !bus_ctrl_oe_out)
      else $error("pin driven before start-up");

   // pin routing and drive checks beyond the idle cases
   a_data_route: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg |-> ((portf_bit9_pin_out ^ data_line_wr_in) & pf_per_reg) == pin_share_pkg::PF_ZERO)
      else $error("data lines not routed");
   a_rd_data_path: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg |-> data_line_rd_out == $past(portf_bit9_pin_in, 3))
      else $error("read data path wrong");
   a_pf_gpio_data: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg |-> ((portf_bit9_pin_out ^ pf_dout_reg) & ~pf_per_reg) == pin_share_pkg::PF_ZERO)
      else $error("port f gpio data wrong");
   a_keep_data_drive: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg && bus_drive_keep_reg && !bus_active_in
      |-> (portf_bit9_oe_out & pf_per_reg) == pf_per_reg)
      else $error("kept data lines not driven");
   a_pb_bus_drive: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg && portb_periph_enable_reg && (bus_active_in || bus_drive_keep_reg)
      |-> portb_bit0_oe_out)
      else $error("address line 16 not driven");
   a_ctrl_drive: assert property (@(posedge clk_in) disable iff (rst_in)
      init_done_reg |-> bus_ctrl_oe_out == (bus_active_in || bus_drive_keep_reg)
                        && bus_ctrl_pin_out == bus_ctrl_in)
      else $error("bus control pins wrong");

endmodule

// ==== ext_mem_model.sv ====
module ext_mem_model (
   // clock and bus control from the block
   input  wire logic       clk_in,
   input  wire logic [2:0] ctrl_in,
   // data pins as the block drives them
   input  wire logic [6:0] oe_in,
   input  wire logic [6:0] out_in,
   input  wire logic [6:0] pullup_in,
   // resolved pin level
   output logic      [6:0] level_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] mem_reg = 7'h55;
   logic [6:0] last_reg = 7'h2A;
   // select plus write strobe stores the word on the data lines
   always @(posedge clk_in) begin
      if (ctrl_in == 3'h5 && oe_in == 7'h7F)
         mem_reg <= out_in;
      last_reg <= level_out;
   end
   // select plus read strobe drives; released lines without a pull-up never keep the old value
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         if (oe_in[i])
            level_out[i] = out_in[i];
         else if (ctrl_in == 3'h3)
            level_out[i] = mem_reg[i];
         else
            level_out[i] = pullup_in[i] | ~last_reg[i];
      end
   end
endmodule

// ==== testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // signals
   logic        clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
   logic        external_boot_strap_in = 1'b0, ext_iface_width_select_in = 1'b0, flash_secure_in = 1'b0;
   logic        bus_active_in = 1'b0, addr_line_16_in = 1'b0, data_drive_in = 1'b0, pb_ext = 1'b0;
   logic [6:0]  data_line_wr_in = 7'h00, data_line_rd_out, portf_bit9_pin_in, portf_bit9_pin_out;
   logic [6:0]  portf_bit9_oe_out, portf_bit9_pullup_out, pf_per, pf_dir, pf_dout, pf_pur;
   logic [2:0]  bus_ctrl_in = 3'h0, bus_ctrl_pin_out;
   logic        pready_out, pslverr_out, bus_ctrl_oe_out, portb_bit0_pin_in, portb_bit0_pin_out;
   logic        portb_bit0_oe_out, portb_bit0_pullup_out, err, boot, act, pe, po;
   logic        pb_per, pb_dir, pb_dout, pb_pur, keep;
   logic [13:0] v;
   int          seed = 49841;
   int          fails = 0;
   int          num_checks = 0;
   // clock and the port b pin wire
   always #20 clk_in = ~clk_in;
   assign portb_bit0_pin_in = portb_bit0_oe_out ? portb_bit0_pin_out : pb_ext;
   // ==========================================
   // design and far-side memory
   ext_bus_gpio_pin_sharing DUT (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .external_boot_strap_in, .ext_iface_width_select_in,
      .flash_secure_in, .bus_active_in, .addr_line_16_in, .data_line_wr_in, .data_drive_in, .bus_ctrl_in,
      .data_line_rd_out, .bus_ctrl_pin_out, .bus_ctrl_oe_out, .portb_bit0_pin_in, .portb_bit0_pin_out,
      .portb_bit0_oe_out, .portb_bit0_pullup_out, .portf_bit9_pin_in, .portf_bit9_pin_out,
      .portf_bit9_oe_out, .portf_bit9_pullup_out);
   ext_mem_model mem (.clk_in, .ctrl_in(bus_ctrl_pin_out), .oe_in(portf_bit9_oe_out),
      .out_in(portf_bit9_pin_out), .pullup_in(portf_bit9_pullup_out), .level_out(portf_bit9_pin_in));
   // ==========================================
   // tasks and expectation functions
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (e !== g) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer, setup then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 16);
      if (pready_out !== 1'b1) begin
         fails++;
         finish_test();
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   function automatic logic [6:0] mix(input logic [6:0] per, input logic [6:0] bus, input logic [6:0] io);
      return (per & bus) | (~per & io);
   endfunction
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      finish_test();
   end
   // ==========================================
   // main sequence
   initial begin
      {external_boot_strap_in, ext_iface_width_select_in, flash_secure_in} = 3'($random(seed));
      boot = external_boot_strap_in | (ext_iface_width_select_in & ~flash_secure_in);
      repeat (2) @(posedge clk_in);
      chk("oe in reset", 32'h0000_0000, {portf_bit9_oe_out, portb_bit0_oe_out});
      chk("pull-ups in reset", 32'h0000_00FF, {portf_bit9_pullup_out, portb_bit0_pullup_out});
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      apb(1'b0, pin_share_pkg::OFF_PB_PER, 32'h0000_0000);
      chk("boot choice", {31'h0000_0000, boot}, rd);
      apb(1'b0, pin_share_pkg::OFF_STATUS, 32'h0000_0000);
      chk("status", {29'h0000_0000, 1'b1, boot, 1'b0}, rd);
      apb(1'b0, 8'h30, 32'hFFFF_FFFF);
      chk("unmapped", 32'h0000_0001, {rd[30:0], err});
      $display("test reset done");
      // random mux setups, first two force an idle bus in bus mode
      for (int i = 0; i < 12; i++) begin
         {pb_per, pb_dir, pb_dout, pb_pur, keep} = 5'($random(seed));
         {pf_per, pf_dir, pf_dout} = 21'($random(seed));
         pf_pur = 7'($random(seed));
         v = 14'($random(seed));
         if (i < 2) begin
            pb_per = 1'b1;
            pf_per = 7'h7F;
            keep = i[0];
         end
         act = v[0] & (i > 1);
         pe = pb_per ? act | keep : pb_dir;
         po = pb_per ? v[1] : pb_dout;
         apb(1'b1, pin_share_pkg::OFF_BUS_CTRL, {31'h0000_0000, keep});
         apb(1'b1, pin_share_pkg::OFF_PB_PER, {31'h0000_0000, pb_per});
         apb(1'b1, pin_share_pkg::OFF_PB_DIR, {31'h0000_0000, pb_dir});
         apb(1'b1, pin_share_pkg::OFF_PB_DOUT, {31'h0000_0000, pb_dout});
         apb(1'b1, pin_share_pkg::OFF_PB_PUR, {31'h0000_0000, pb_pur});
         apb(1'b1, pin_share_pkg::OFF_PF_PER, {16'h0000, pf_per, 9'h000});
         apb(1'b1, pin_share_pkg::OFF_PF_DIR, {16'h0000, pf_dir, 9'h000});
         apb(1'b1, pin_share_pkg::OFF_PF_DOUT, {16'h0000, pf_dout, 9'h000});
         apb(1'b1, pin_share_pkg::OFF_PF_PUR, {16'h0000, pf_pur, 9'h000});
         @(posedge clk_in);
         bus_active_in <= act;
         addr_line_16_in <= v[1];
         data_drive_in <= v[2];
         pb_ext <= v[3];
         data_line_wr_in <= v[10:4];
         bus_ctrl_in <= v[13:11];
         @(posedge clk_in);
         chk("pb oe", pe, portb_bit0_oe_out);
         chk("pb out", po, portb_bit0_pin_out);
         chk("pf oe", mix(pf_per, act ? {7{v[2]}} : {7{keep}}, pf_dir), portf_bit9_oe_out);
         chk("pf out", mix(pf_per, v[10:4], pf_dout), portf_bit9_pin_out);
         chk("pull-ups", {pf_pur, pb_pur}, {portf_bit9_pullup_out, portb_bit0_pullup_out});
         chk("ctrl", {act | keep, v[13:11]}, {bus_ctrl_oe_out, bus_ctrl_pin_out});
         repeat (3) @(posedge clk_in);
         apb(1'b0, pin_share_pkg::OFF_PB_DIN, 32'h0000_0000);
         chk("pb pin in", {31'h0000_0000, pe ? po : v[3]}, rd);
         apb(1'b0, pin_share_pkg::OFF_PB_PER, 32'h0000_0000);
         chk("pb enable", {31'h0000_0000, pb_per}, rd);
      end
      $display("test mux done");
      // memory write then read back through the data lines
      apb(1'b1, pin_share_pkg::OFF_PF_PER, 32'h0000_FE00);
      @(posedge clk_in);
      bus_active_in <= 1'b1;
      data_drive_in <= 1'b1;
      data_line_wr_in <= 7'h3A;
      bus_ctrl_in <= 3'h5;
      repeat (2) @(posedge clk_in);
      data_drive_in <= 1'b0;
      bus_ctrl_in <= 3'h3;
      repeat (5) @(posedge clk_in);
      chk("read data", 32'h0000_003A, data_line_rd_out);
      bus_active_in <= 1'b0;
      bus_ctrl_in <= 3'h0;
      // floating port f inputs read high through the pull-ups
      apb(1'b1, pin_share_pkg::OFF_PF_PER, 32'h0000_0000);
      apb(1'b1, pin_share_pkg::OFF_PF_DIR, 32'h0000_0000);
      apb(1'b1, pin_share_pkg::OFF_PF_PUR, 32'h0000_FE00);
      repeat (4) @(posedge clk_in);
      apb(1'b0, pin_share_pkg::OFF_PF_DIN, 32'h0000_0000);
      chk("pf pin in", 32'h0000_FE00, rd);
      $display("test memory done");
      finish_test();
   end
endmodule
